// *** hw/gpio_pkg.sv ***
package gpio_pkg;
  // ==========================================================
  // register offsets in the i/o space
  localparam logic [5:0] ADDR_PORT_A_IN = 6'h00;
  localparam logic [5:0] ADDR_PORT_A_DIR = 6'h01;
  localparam logic [5:0] ADDR_PORT_A_OUT = 6'h02;
  localparam logic [5:0] ADDR_PORT_B_IN = 6'h03;
  localparam logic [5:0] ADDR_PORT_B_DIR = 6'h04;
  localparam logic [5:0] ADDR_PORT_B_OUT = 6'h05;
  localparam logic [5:0] ADDR_PORT_C_OUT = 6'h08;
  localparam logic [5:0] ADDR_PROC_CTRL = 6'h35;
  // ==========================================================
  // processor control field positions
  localparam int CTRL_SCAN_OFF_BIT = 7;
  localparam int CTRL_PULLUP_OFF_BIT = 4;
  localparam int CTRL_VEC_SEL_BIT = 1;
  localparam int CTRL_VEC_UNLOCK_BIT = 0;
  // only these bits hold written data, the rest read as zero
  localparam logic [7:0] CTRL_WRITE_MASK = 8'h93;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] PORT_RESET = 8'h00;
  // ==========================================================
  // timing
  localparam int CLK_MHZ = 200;
  localparam int SPIKE_NS = 50;
  // least time to accept a level, rounded up to whole cycles
  localparam int SPIKE_CYCLES = (SPIKE_NS * CLK_MHZ + 999) / 1000;
  localparam int SYNC_STAGES = 2;
endpackage

// *** hw/pin_sync.sv ***
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk_i,               // system clock
  input wire logic rst_i,               // synchronous reset, high
  input wire logic [WIDTH-1:0] d_i,     // asynchronous pin levels
  output logic [WIDTH-1:0] q_o          // levels in clk_i domain
);
  logic [WIDTH-1:0] stage1;

  // ==========================================================
  // two-flop synchroniser; stage1 feeds only q_o
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stage1 <= '0;
      q_o <= '0;
    end else begin
      stage1 <= d_i;
      q_o <= stage1;
    end
  end
endmodule

// *** hw/port_pin_override.sv ***
`timescale 1ns/1ps
module port_pin_override (
  input wire logic clk_i,                          // system clock
  input wire logic rst_i,                          // synchronous reset
  input wire logic [5:0] io_addr_i,                // i/o register address
  input wire logic [7:0] io_wdata_i,               // write data
  input wire logic io_we_i,                        // write strobe
  input wire logic io_re_i,                        // read strobe
  output logic [7:0] io_rdata_o,                   // read data, held
  input wire logic [7:0] port_a_pin_i,             // port A pin levels
  output logic [7:0] port_a_out_o,                 // port A drive value
  output logic [7:0] port_a_oe_o,                  // port A drive enable
  output logic [7:0] port_a_pullup_o,              // port A pull-up on
  input wire logic [7:0] port_b_pin_i,             // port B pin levels
  output logic [7:0] port_b_out_o,                 // port B drive value
  output logic [7:0] port_b_oe_o,                  // port B drive enable
  output logic [7:0] port_b_pullup_o,              // port B pull-up on
  input wire logic [7:0] port_c_pin_i,             // port C pin levels
  input wire logic [7:0] port_c_output_data_direction_i,        // port C direction
  output logic [7:0] port_c_out_o,                 // port C drive value
  output logic [7:0] port_c_oe_o,                  // port C drive enable
  output logic [7:0] port_c_pullup_o,              // port C pull-up on
  input wire logic [7:0] port_d_pin_i,             // port D pin levels
  input wire logic [7:0] portd_direction_i,        // port D direction
  input wire logic [7:0] portd_output_data_i,      // port D data bits
  output logic [7:0] port_d_out_o,                 // port D drive value
  output logic [7:0] port_d_oe_o,                  // port D drive enable
  output logic [7:0] port_d_pullup_o,              // port D pull-up on
  input wire logic serial0_receiver_on_i,          // serial0 rx enabled
  input wire logic serial0_transmitter_on_i,       // serial0 tx enabled
  input wire logic serial0_tx_data_i,              // serial0 tx bit
  input wire logic serial1_receiver_on_i,          // serial1 rx enabled
  input wire logic two_wire_on_i,                  // two-wire enabled
  input wire logic [3:0] timer_compare_enable_i,   // compare out en, bits 7..4
  input wire logic [3:0] timer_compare_value_i,    // compare out, bits 7..4
  input wire logic [3:0] external_irq_enable_i,    // ext irq en, bits 3..0
  input wire logic [7:0] pinchange_source_d_i,     // pin-change masks
  input wire logic pinchange_group3_enable_i,      // pin-change group 3
  input wire logic sleep_i,                        // port D interrupt-side levels gated in sleep
  output logic [7:0] portd_levels_o,               // gated port D levels
  output logic [7:0] pinchange_d_o,                // pin-change sources 24..31
  output logic external_irq_zero_o,                // ext irq zero level
  output logic two_wire_scl_o,                     // filtered clock line
  output logic two_wire_sda_o,                     // filtered data line
  output logic global_pullup_off_o,                // pull-up disable bit
  output logic scan_port_disable_o,                // scan port disable bit
  output logic vector_table_select_o,              // vector table select
  output logic vector_change_unlock_o              // vector change unlock
);
  logic [7:0] port_a_direction;
  logic [7:0] port_a_output_data;
  logic [7:0] port_b_direction;
  logic [7:0] port_b_output_data;
  logic [7:0] port_c_output_data;
  logic [7:0] processor_control;
  logic [31:0] pins_sync;
  logic [7:0] sync_a;
  logic [7:0] sync_b;
  logic [7:0] sync_d;
  logic pullups_off;

  // ==========================================================
  // pin synchronisation
  // every pin level passes two flops before use
  pin_sync #(.WIDTH(32)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({port_d_pin_i, port_c_pin_i, port_b_pin_i, port_a_pin_i}),
    .q_o(pins_sync)
  );
  assign sync_a = pins_sync[7:0];
  assign sync_b = pins_sync[15:8];
  assign sync_d = pins_sync[31:24];
  assign pullups_off = processor_control[gpio_pkg::CTRL_PULLUP_OFF_BIT];

  // ==========================================================
  // register decode
  wire wr_a_in = io_we_i && (io_addr_i == gpio_pkg::ADDR_PORT_A_IN);
  wire wr_a_dir = io_we_i && (io_addr_i == gpio_pkg::ADDR_PORT_A_DIR);
  wire wr_a_out = io_we_i && (io_addr_i == gpio_pkg::ADDR_PORT_A_OUT);
  wire wr_b_in = io_we_i && (io_addr_i == gpio_pkg::ADDR_PORT_B_IN);
  wire wr_b_dir = io_we_i && (io_addr_i == gpio_pkg::ADDR_PORT_B_DIR);
  wire wr_b_out = io_we_i && (io_addr_i == gpio_pkg::ADDR_PORT_B_OUT);
  wire wr_c_out = io_we_i && (io_addr_i == gpio_pkg::ADDR_PORT_C_OUT);
  wire wr_ctrl = io_we_i && (io_addr_i == gpio_pkg::ADDR_PROC_CTRL);

  // writing ones to an input level register toggles the data bits
  wire [7:0] next_a_out = wr_a_out ? io_wdata_i :
                          wr_a_in ? (port_a_output_data ^ io_wdata_i) : port_a_output_data;
  wire [7:0] next_b_out = wr_b_out ? io_wdata_i :
                          wr_b_in ? (port_b_output_data ^ io_wdata_i) : port_b_output_data;

  // read mux; unmapped addresses read zero
  wire [7:0] next_rdata =
    (io_addr_i == gpio_pkg::ADDR_PORT_A_IN) ? sync_a :
    (io_addr_i == gpio_pkg::ADDR_PORT_A_DIR) ? port_a_direction :
    (io_addr_i == gpio_pkg::ADDR_PORT_A_OUT) ? port_a_output_data :
    (io_addr_i == gpio_pkg::ADDR_PORT_B_IN) ? sync_b :
    (io_addr_i == gpio_pkg::ADDR_PORT_B_DIR) ? port_b_direction :
    (io_addr_i == gpio_pkg::ADDR_PORT_B_OUT) ? port_b_output_data :
    (io_addr_i == gpio_pkg::ADDR_PORT_C_OUT) ? port_c_output_data :
    (io_addr_i == gpio_pkg::ADDR_PROC_CTRL) ? processor_control : 8'h00;

  // ==========================================================
  // register file
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_a_direction <= gpio_pkg::PORT_RESET;
      port_a_output_data <= gpio_pkg::PORT_RESET;
      port_b_direction <= gpio_pkg::PORT_RESET;
      port_b_output_data <= gpio_pkg::PORT_RESET;
      port_c_output_data <= gpio_pkg::PORT_RESET;
      processor_control <= gpio_pkg::CTRL_RESET;
      io_rdata_o <= 8'h00;
    end else begin
      if (wr_a_dir) port_a_direction <= io_wdata_i;
      if (wr_b_dir) port_b_direction <= io_wdata_i;
      if (wr_c_out) port_c_output_data <= io_wdata_i;
      port_a_output_data <= next_a_out;
      port_b_output_data <= next_b_out;
      if (wr_ctrl) processor_control <= io_wdata_i & gpio_pkg::CTRL_WRITE_MASK;
      if (io_re_i) io_rdata_o <= next_rdata;
    end
  end

  // ==========================================================
  // plain port pull-up: input, data bit set, global disable clear
  function automatic logic [7:0] pull_of(input logic [7:0] dir, input logic [7:0] dat,
                                         input logic off);
    pull_of = off ? 8'h00 : (~dir & dat);
  endfunction

  // ==========================================================
  // port D overrides
  // receivers force input, transmitter forces output
  wire [7:0] dir_force_en = {5'h00, serial1_receiver_on_i, serial0_transmitter_on_i,
                             serial0_receiver_on_i};
  wire [7:0] dir_force_val = {5'h00, 1'b0, 1'b1, 1'b0};
  wire [7:0] d_dir = (portd_direction_i & ~dir_force_en) | (dir_force_val & dir_force_en);
  // forced inputs keep their data-bit pull-up; forced output has none
  wire [7:0] d_pull_forced = pullups_off ? 8'h00 : (portd_output_data_i & ~dir_force_val);
  wire [7:0] d_pull = (pull_of(portd_direction_i, portd_output_data_i, pullups_off) & ~dir_force_en) |
                      (d_pull_forced & dir_force_en);
  // compare outputs on bits 7..4, transmitter bit on bit 1
  wire [7:0] val_ovr_en = {timer_compare_enable_i, 2'b00, serial0_transmitter_on_i, 1'b0};
  wire [7:0] val_ovr = {timer_compare_value_i, 2'b00, serial0_tx_data_i, 1'b0};
  wire [7:0] d_val = (portd_output_data_i & ~val_ovr_en) | (val_ovr & val_ovr_en);
  // input buffer override; in sleep only overridden pins reach d_level, the two-wire filter still reads sync_d
  wire [7:0] pc_on = pinchange_source_d_i & {8{pinchange_group3_enable_i}};
  wire [7:0] die_ovr = pc_on | {4'h0, external_irq_enable_i};
  wire [7:0] d_die = {8{~sleep_i}} | die_ovr;
  wire [7:0] d_level = sync_d & d_die;

  // ==========================================================
  // pin outputs, all registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_a_out_o <= 8'h00;
      port_a_oe_o <= 8'h00;
      port_a_pullup_o <= 8'h00;
      port_b_out_o <= 8'h00;
      port_b_oe_o <= 8'h00;
      port_b_pullup_o <= 8'h00;
      port_c_out_o <= 8'h00;
      port_c_oe_o <= 8'h00;
      port_c_pullup_o <= 8'h00;
      port_d_out_o <= 8'h00;
      port_d_oe_o <= 8'h00;
      port_d_pullup_o <= 8'h00;
    end else begin
      port_a_out_o <= port_a_output_data;
      port_a_oe_o <= port_a_direction;
      port_a_pullup_o <= pull_of(port_a_direction, port_a_output_data, pullups_off);
      port_b_out_o <= port_b_output_data;
      port_b_oe_o <= port_b_direction;
      port_b_pullup_o <= pull_of(port_b_direction, port_b_output_data, pullups_off);
      port_c_out_o <= port_c_output_data;
      port_c_oe_o <= port_c_output_data_direction_i;
      port_c_pullup_o <= pull_of(port_c_output_data_direction_i, port_c_output_data, pullups_off);
      port_d_out_o <= d_val;
      port_d_oe_o <= d_dir;
      port_d_pullup_o <= d_pull;
    end
  end

  // ==========================================================
  // interrupt-side levels and control bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      portd_levels_o <= 8'h00;
      pinchange_d_o <= 8'h00;
      external_irq_zero_o <= 1'b0;
      global_pullup_off_o <= 1'b0;
      scan_port_disable_o <= 1'b0;
      vector_table_select_o <= 1'b0;
      vector_change_unlock_o <= 1'b0;
    end else begin
      portd_levels_o <= d_level;
      pinchange_d_o <= d_level & pinchange_source_d_i;
      external_irq_zero_o <= d_level[2];
      global_pullup_off_o <= pullups_off;
      scan_port_disable_o <= processor_control[gpio_pkg::CTRL_SCAN_OFF_BIT];
      vector_table_select_o <= processor_control[gpio_pkg::CTRL_VEC_SEL_BIT];
      vector_change_unlock_o <= processor_control[gpio_pkg::CTRL_VEC_UNLOCK_BIT];
    end
  end

  // ==========================================================
  // two-wire spike filters on port D bits 0 (clock) and 1 (data)
  // a level must hold SPIKE_CYCLES samples before it is passed on;
  // this adds that much latency to every genuine edge
  localparam int CW = $clog2(gpio_pkg::SPIKE_CYCLES + 1);
  localparam logic [CW-1:0] SPIKE_LAST = CW'(gpio_pkg::SPIKE_CYCLES - 1);
  logic [CW-1:0] stable_cnt [2];
  wire [1:0] tw_raw = sync_d[1:0];
  wire [1:0] tw_now = {two_wire_sda_o, two_wire_scl_o};
  wire [1:0] tw_take = {stable_cnt[1] == SPIKE_LAST, stable_cnt[0] == SPIKE_LAST};
  logic [1:0] tw_next;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stable_cnt[0] <= '0;
      stable_cnt[1] <= '0;
      tw_next <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (!two_wire_on_i || tw_raw[i] == tw_now[i] || tw_take[i]) begin
          stable_cnt[i] <= '0;
        end else begin
          stable_cnt[i] <= stable_cnt[i] + 1'b1;
        end
        if (!two_wire_on_i || tw_take[i]) begin
          tw_next[i] <= tw_raw[i];
        end
      end
    end
  end
  assign two_wire_scl_o = tw_next[0];
  assign two_wire_sda_o = tw_next[1];

  // ==========================================================
  // checks
  property p_rx1_input;
    @(posedge clk_i) disable iff (rst_i) serial1_receiver_on_i |=> !port_d_oe_o[2];
  endproperty
  a_rx1_input: assert property (p_rx1_input) else $error("rx1 pin not input");

  property p_rx1_pull;
    @(posedge clk_i) disable iff (rst_i)
      serial1_receiver_on_i && !pullups_off |=> port_d_pullup_o[2] == $past(portd_output_data_i[2]);
  endproperty
  a_rx1_pull: assert property (p_rx1_pull) else $error("rx1 pull-up wrong");

  property p_tx0_output;
    @(posedge clk_i) disable iff (rst_i)
      serial0_transmitter_on_i |=> port_d_oe_o[1] && port_d_out_o[1] == $past(serial0_tx_data_i);
  endproperty
  a_tx0_output: assert property (p_tx0_output) else $error("tx0 pin not driven");

  property p_rx0_input;
    @(posedge clk_i) disable iff (rst_i)
      serial0_receiver_on_i |=> !port_d_oe_o[0] &&
        port_d_pullup_o[0] == ($past(portd_output_data_i[0]) && !$past(pullups_off));
  endproperty
  a_rx0_input: assert property (p_rx0_input) else $error("rx0 pin wrong");

  property p_compare_value;
    @(posedge clk_i) disable iff (rst_i)
      timer_compare_enable_i[3] |=> port_d_out_o[7] == $past(timer_compare_value_i[3]) &&
        port_d_oe_o[7] == $past(portd_direction_i[7]);
  endproperty
  a_compare_value: assert property (p_compare_value) else $error("compare value wrong");

  property p_irq_input_on;
    @(posedge clk_i) disable iff (rst_i)
      sleep_i && external_irq_enable_i[0] |=> portd_levels_o[0] == $past(sync_d[0]);
  endproperty
  a_irq_input_on: assert property (p_irq_input_on) else $error("input buffer off");

  property p_irq_zero;
    @(posedge clk_i) disable iff (rst_i) !sleep_i |=> external_irq_zero_o == $past(sync_d[2]);
  endproperty
  a_irq_zero: assert property (p_irq_zero) else $error("irq zero mismatch");

  property p_pinchange;
    @(posedge clk_i) disable iff (rst_i)
      !sleep_i |=> pinchange_d_o[2:0] == ($past(sync_d[2:0]) & $past(pinchange_source_d_i[2:0]));
  endproperty
  a_pinchange: assert property (p_pinchange) else $error("pin-change source wrong");

  property p_pullups_off;
    @(posedge clk_i) disable iff (rst_i)
      pullups_off |=> port_a_pullup_o == 8'h00 && port_b_pullup_o == 8'h00 && port_c_pullup_o == 8'h00;
  endproperty
  a_pullups_off: assert property (p_pullups_off) else $error("pull-up despite disable");

  property p_filter_hold;
    @(posedge clk_i) disable iff (rst_i)
      two_wire_on_i && $past(two_wire_on_i) && $changed(two_wire_scl_o) |-> $past(tw_take[0]);
  endproperty
  a_filter_hold: assert property (p_filter_hold) else $error("spike passed filter");

  property p_ctrl_ro;
    @(posedge clk_i) disable iff (rst_i)
      wr_ctrl |=> processor_control[6:5] == 2'b00 && processor_control[3:2] == 2'b00 &&
        pullups_off == $past(io_wdata_i[4]);
  endproperty
  a_ctrl_ro: assert property (p_ctrl_ro) else $error("control bits wrong");

  property p_read_pins;
    @(posedge clk_i) disable iff (rst_i)
      io_re_i && io_addr_i == gpio_pkg::ADDR_PORT_B_IN |=> io_rdata_o == $past(sync_b);
  endproperty
  a_read_pins: assert property (p_read_pins) else $error("pin read wrong");

  property p_reset_zero;
    @(posedge clk_i) rst_i |=> port_a_oe_o == 8'h00 && port_b_out_o == 8'h00 && processor_control == 8'h00;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("reset values wrong");

  c_rx0: cover property (@(posedge clk_i) disable iff (rst_i) serial0_receiver_on_i ##1 port_d_pullup_o[0]);
  c_filter: cover property (@(posedge clk_i) disable iff (rst_i) two_wire_on_i ##1 $changed(two_wire_sda_o));
  c_pullups_off: cover property (@(posedge clk_i) disable iff (rst_i) $rose(pullups_off));
endmodule

// *** dv/board_pins.sv ***
`timescale 1ns/1ps
// ==========================================================
// board side of one 8-bit port
module board_pins (
  input wire logic clk_i,           // system clock
  input wire logic [7:0] out_i,     // device drive value
  input wire logic [7:0] oe_i,      // device drive enable
  input wire logic [7:0] pullup_i,  // device pull-up on
  input wire logic [7:0] ext_val_i, // board drive value
  input wire logic [7:0] ext_en_i,  // board drive enable
  output logic [7:0] pin_o          // resolved pin level
);
  logic [7:0] flt = 8'h00;
  // a floating pin wanders so a missing pull-up cannot pass by luck
  always @(posedge clk_i) begin
    flt <= ~flt;
  end
  // contention on a pin shows as unknown
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (oe_i[i] && ext_en_i[i]) pin_o[i] = 1'bx;
      else if (oe_i[i]) pin_o[i] = out_i[i];
      else if (ext_en_i[i]) pin_o[i] = ext_val_i[i];
      else if (pullup_i[i]) pin_o[i] = 1'b1;
      else pin_o[i] = flt[i];
    end
  end
endmodule

// *** dv/tb.sv ***
`timescale 1ns/1ps
module tb;
  // ==========================================================
  // stimulus and observed signals
  logic clk_i = 0, rst_i = 1, io_we_i = 0, io_re_i = 0;
  logic [5:0] io_addr_i = 6'h00;
  logic [7:0] io_wdata_i = 8'h00, io_rdata_o, rd_val;
  logic [7:0] pin[4], out[4], oe[4], pu[4], xv[4], xe[4];
  logic [7:0] c_dir = 8'h00, d_dir = 8'h00, d_dat = 8'h00, pc_src = 8'h00, lv, pc_o;
  logic s0rx = 0, s0tx = 0, s0txd = 0, s1rx = 0, twi_on = 0, pc_grp = 0, sleep = 0;
  logic [3:0] cmp_en = 4'h0, cmp_val = 4'h0, irq_en = 4'h0;
  logic irq0, scl, sda, pull_off_o, scan_o, vsel_o, vunl_o;
  int n_fail = 0, checked = 0;
  // clock and board models
  initial forever #2.5 clk_i = ~clk_i;
  initial for (int k = 0; k < 4; k++) begin
    xv[k] = 8'h00;
    xe[k] = 8'h00;
  end
  for (genvar g = 0; g < 4; g++) begin : g_board
    board_pins brd (.clk_i(clk_i), .out_i(out[g]), .oe_i(oe[g]), .pullup_i(pu[g]),
      .ext_val_i(xv[g]), .ext_en_i(xe[g]), .pin_o(pin[g]));
  end
  port_pin_override uut (.clk_i(clk_i), .rst_i(rst_i), .io_addr_i(io_addr_i), .io_wdata_i(io_wdata_i),
    .io_we_i(io_we_i), .io_re_i(io_re_i), .io_rdata_o(io_rdata_o),
    .port_a_pin_i(pin[0]), .port_a_out_o(out[0]), .port_a_oe_o(oe[0]), .port_a_pullup_o(pu[0]),
    .port_b_pin_i(pin[1]), .port_b_out_o(out[1]), .port_b_oe_o(oe[1]), .port_b_pullup_o(pu[1]),
    .port_c_pin_i(pin[2]), .port_c_output_data_direction_i(c_dir), .port_c_out_o(out[2]), .port_c_oe_o(oe[2]),
    .port_c_pullup_o(pu[2]), .port_d_pin_i(pin[3]), .portd_direction_i(d_dir),
    .portd_output_data_i(d_dat), .port_d_out_o(out[3]), .port_d_oe_o(oe[3]), .port_d_pullup_o(pu[3]),
    .serial0_receiver_on_i(s0rx), .serial0_transmitter_on_i(s0tx), .serial0_tx_data_i(s0txd),
    .serial1_receiver_on_i(s1rx), .two_wire_on_i(twi_on), .timer_compare_enable_i(cmp_en),
    .timer_compare_value_i(cmp_val), .external_irq_enable_i(irq_en), .pinchange_source_d_i(pc_src),
    .pinchange_group3_enable_i(pc_grp), .sleep_i(sleep), .portd_levels_o(lv), .pinchange_d_o(pc_o),
    .external_irq_zero_o(irq0), .two_wire_scl_o(scl), .two_wire_sda_o(sda),
    .global_pullup_off_o(pull_off_o), .scan_port_disable_o(scan_o), .vector_table_select_o(vsel_o),
    .vector_change_unlock_o(vunl_o));
  // ==========================================================
  // shared tasks
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_i);
    io_we_i <= 1'b1;
    io_addr_i <= a;
    io_wdata_i <= d;
    @(posedge clk_i);
    io_we_i <= 1'b0;
  endtask
  // read data lands on the edge that takes the strobe
  task automatic rd(input logic [5:0] a);
    @(posedge clk_i);
    io_re_i <= 1'b1;
    io_addr_i <= a;
    @(posedge clk_i);
    io_re_i <= 1'b0;
    #1 rd_val = io_rdata_o;
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs;
    logic [5:0] rw[5] = '{gpio_pkg::ADDR_PORT_A_DIR, gpio_pkg::ADDR_PORT_A_OUT, gpio_pkg::ADDR_PORT_B_DIR,
      gpio_pkg::ADDR_PORT_B_OUT, gpio_pkg::ADDR_PORT_C_OUT};
    rd(gpio_pkg::ADDR_PROC_CTRL);
    chk("ctrl reset", 8'h00, rd_val);
    for (int i = 0; i < 5; i++) begin
      rd(rw[i]);
      chk("port reg reset", 8'h00, rd_val);
      wr(rw[i], 8'h5A ^ 8'(i));
      rd(rw[i]);
      chk("port reg rw", 8'h5A ^ 8'(i), rd_val);
    end
    wr(gpio_pkg::ADDR_PROC_CTRL, 8'hFF);
    rd(gpio_pkg::ADDR_PROC_CTRL);
    chk("ctrl read-only bits", 8'h93, rd_val);
    chk("pullup off out", 8'h01, {7'h00, pull_off_o});
    chk("ctrl bit outputs", 8'h93, {scan_o, 2'b00, pull_off_o, 2'b00, vsel_o, vunl_o});
    wr(gpio_pkg::ADDR_PROC_CTRL, 8'h00);
    rd(6'h3F);
    chk("unmapped read", 8'h00, rd_val);
    // port c direction comes from outside; low nibble driven, high nibble pulled only where data bits are set
    @(posedge clk_i);
    c_dir <= 8'h0F;
    settle(2);
    chk("port c oe", 8'h0F, oe[2]);
    chk("port c out", 8'h5E, out[2]);
    chk("port c pullup", 8'h50, pu[2]);
    chk("port b oe", 8'h58, oe[1]);
    chk("port b pullup", 8'h01, pu[1]);
  endtask
  task automatic t_port_ab;
    wr(gpio_pkg::ADDR_PORT_A_DIR, 8'hF0);
    wr(gpio_pkg::ADDR_PORT_A_OUT, 8'h3C);
    settle(2);
    chk("port a oe", 8'hF0, oe[0]);
    chk("port a out", 8'h30, out[0] & 8'hF0);
    chk("port a pullup", 8'h0C, pu[0]);
    settle(3);
    rd(gpio_pkg::ADDR_PORT_A_IN);
    chk("port a levels", 8'h3C, rd_val & 8'hFC);
    wr(gpio_pkg::ADDR_PROC_CTRL, 8'h10);
    settle(3);
    chk("pullup disabled", 8'h00, pu[0]);
    wr(gpio_pkg::ADDR_PORT_B_DIR, 8'h00);
    wr(gpio_pkg::ADDR_PORT_B_OUT, 8'h00);
    xv[1] <= 8'hA6;
    xe[1] <= 8'hFF;
    settle(4);
    rd(gpio_pkg::ADDR_PORT_B_IN);
    chk("port b levels", 8'hA6, rd_val);
    wr(gpio_pkg::ADDR_PORT_B_IN, 8'h0F);
    rd(gpio_pkg::ADDR_PORT_B_OUT);
    chk("port b toggle", 8'h0F, rd_val);
    wr(gpio_pkg::ADDR_PROC_CTRL, 8'h00);
  endtask
  task automatic t_port_d_over;
    @(posedge clk_i);
    d_dir <= 8'hF5;
    d_dat <= 8'h05;
    {s0rx, s0tx, s0txd, s1rx} <= 4'hF;
    cmp_en <= 4'hA;
    cmp_val <= 4'h8;
    settle(2);
    chk("port d oe forced", 8'hF2, oe[3]);
    chk("port d pullup forced", 8'h05, pu[3]);
    chk("port d value", 8'h82, out[3] & 8'hF2);
    @(posedge clk_i);
    {s0rx, s0tx, s1rx} <= 3'h0;
    settle(2);
    chk("port d oe released", 8'hF5, oe[3]);
    chk("port d pullup released", 8'h00, pu[3]);
  endtask
  task automatic t_inputs;
    @(posedge clk_i);
    d_dir <= 8'h00;
    cmp_en <= 4'h0;
    // board drives only after the device has let go, so no contention
    @(posedge clk_i);
    xv[3] <= 8'h4F;
    xe[3] <= 8'hFF;
    pc_src <= 8'h47;
    settle(5);
    chk("pin change sources", 8'h47, pc_o);
    chk("ext irq zero", 8'h01, {7'h00, irq0});
    @(posedge clk_i);
    sleep <= 1'b1;
    settle(5);
    chk("sleep gated levels", 8'h00, lv);
    @(posedge clk_i);
    irq_en <= 4'h8;
    pc_grp <= 1'b1;
    settle(5);
    chk("input enable override", 8'h4F, lv);
    @(posedge clk_i);
    {sleep, pc_grp, irq_en, pc_src} <= '0;
  endtask
  // filter must swallow a 5 cycle spike and pass a long level
  task automatic t_twi;
    @(posedge clk_i);
    xv[3] <= 8'h00;
    xe[3] <= 8'h03;
    twi_on <= 1'b1;
    settle(20);
    xv[3] <= 8'h01;
    settle(5);
    xv[3] <= 8'h00;
    settle(20);
    chk("spike dropped", 8'h00, {7'h00, scl});
    xv[3] <= 8'h03;
    settle(8);
    chk("level too young", 8'h00, {6'h00, sda, scl});
    settle(12);
    chk("level passed", 8'h03, {6'h00, sda, scl});
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    settle(1);
    chk("port a oe after reset", 8'h00, oe[0]);
    t_regs();
    t_port_ab();
    t_port_d_over();
    t_inputs();
    t_twi();
    results();
  end
  initial begin
    #50us;
    n_fail++;
    results();
  end
endmodule
